// ### afe_regs_pkg.sv
// Constants for the front end main control register bank
//
// Contract
// RQ1: The sample stage runs at gain one when the gain bit is 0 (reset) and at gain two when it is 1.
// RQ2: The parallel data outputs stay disabled while the output enable bit is 0 (reset) and are driven when it is 1.
// RQ3: The major analog blocks are powered down while the powerdown bit is 1 and fully powered while it is 0 (reset).
// RQ4: Writing 1 to the software reset bit resets the whole system, and the bit then clears itself.
// RQ5: Writing 1 to the scan start bit starts a scan and the bit clears itself; a read of 0 means ready, as after reset.
// RQ6: In single-rate mode a path override of 0 routes all inputs through the red path and 1 routes each through its own path.
// RQ7: Single-rate mode is the one where the converter clock equals the pixel clock, with no multiplication.
// RQ8: The host always writes the three reserved low bits of the third control register as ones, their reset value.
// RQ9: Test patterns replace normal output only in the differential serial format, and test mode 000 (reset) is normal.
// RQ10: Test mode 001 alternates the output word between two fixed complementary values.
// RQ11: Test mode 010 with upcount enable outputs a 21-bit counter stepping from zero to all ones.
// RQ12: Test mode 011 outputs a static 21-bit word built from the high, middle and low count registers.
// RQ13: The automatic clamp pulse is 4, 8 or 16 pixels wide for width codes 00 (reset), 01 and 10.
// RQ14: With automatic clamping on, the clamp pulse is made inside, delayed by a programmable count from the line start.
package afe_regs_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [5:0] IDX_CFG_ONE   = 6'h01;
	localparam logic [5:0] IDX_CTL_TWO   = 6'h02;
	localparam logic [5:0] IDX_CTL_THREE = 6'h03;
	localparam logic [5:0] IDX_CTL_FOUR  = 6'h04;
	localparam logic [5:0] IDX_CLAMP     = 6'h05;
	localparam logic [5:0] IDX_CLAMP_POS = 6'h06;
	localparam logic [5:0] IDX_CNT_LO    = 6'h12;
	localparam logic [5:0] IDX_CNT_MID   = 6'h13;
	localparam logic [5:0] IDX_CNT_HI    = 6'h14;
	localparam logic [5:0] IDX_CLK_MODE  = 6'h20;

	// Values after reset
	localparam logic [7:0] RST_CFG_ONE   = 8'h50;
	localparam logic [7:0] RST_CTL_TWO   = 8'h00;
	localparam logic [7:0] RST_CTL_THREE = 8'h07;
	localparam logic [7:0] RST_CTL_FOUR  = 8'h00;
	localparam logic [7:0] RST_CLAMP     = 8'h00;
	localparam logic [7:0] RST_CLAMP_POS = 8'h27;
	localparam logic [7:0] RST_CNT       = 8'h00;
	localparam logic [1:0] RST_CLK_MODE  = 2'h1;

	// Field positions
	localparam int unsigned B_OFMT   = 3;
	localparam int unsigned B_GAIN   = 4;
	localparam int unsigned B_OE     = 3;
	localparam int unsigned B_PD     = 2;
	localparam int unsigned B_SRST   = 1;
	localparam int unsigned B_SCAN   = 0;
	localparam int unsigned B_OVR    = 3;
	localparam int unsigned B_UPCNT  = 3;
	localparam int unsigned B_AUTO   = 1;
	localparam int unsigned B_CWID   = 2;

	// Test modes and patterns
	localparam logic [2:0]  TP_NORMAL = 3'h0;
	localparam logic [2:0]  TP_ALT    = 3'h1;
	localparam logic [2:0]  TP_COUNT  = 3'h2;
	localparam logic [2:0]  TP_STATIC = 3'h3;
	localparam logic [20:0] PAT_A     = 21'h155555;
	localparam logic [20:0] PAT_B     = 21'h0aaaaa;
	localparam logic [20:0] CNT_MAX   = 21'h1fffff;

	// Clock multiplier code of single-rate mode, clamp base width
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [5:0] CLAMP_BASE  = 6'h04;

	typedef enum logic [1:0]
	{
		CL_IDLE  = 2'b00,
		CL_DELAY = 2'b01,
		CL_PULSE = 2'b10
	} cl_state_t;

endpackage : afe_regs_pkg

// ### clamp_pulse_gen.sv
// Automatic input clamp pulse generator, timed in pixels
`timescale 1ns/1ps
module clamp_pulse_gen
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	// Timing
	input  wire logic       pixel_en,
	input  wire logic       line_start_pulse,
	input  wire logic       soft_rst,
	// Settings
	input  wire logic       auto_en,
	input  wire logic [1:0] width_sel,
	input  wire logic [7:0] position,
	// Pulse
	output logic            clamp_r
);
	import afe_regs_pkg::*;

	cl_state_t   state_r;
	logic        ls_d_r;
	logic [7:0]  cnt_r;
	logic        ls_fall;

	assign ls_fall = ls_d_r & ~line_start_pulse;

	// Line start history for the falling edge
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			ls_d_r <= 1'b0;
		else
			ls_d_r <= line_start_pulse;
	end

	// Delay then width, both counted in pixels [RQ14]
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r <= CL_IDLE;
			cnt_r   <= 8'h00;
			clamp_r <= 1'b0;
		end
		else if (soft_rst || !auto_en)
		begin
			state_r <= CL_IDLE;
			clamp_r <= 1'b0;
		end
		else
		begin
			unique case (state_r)
				CL_IDLE:
					if (ls_fall)
					begin
						state_r <= CL_DELAY;
						cnt_r   <= position; // [RQ14]
					end
				CL_DELAY:
					if (pixel_en)
					begin
						if (cnt_r == 8'h00)
						begin
							state_r <= CL_PULSE;
							clamp_r <= 1'b1;
							// 4 shifted by code: 4, 8, 16, 32 [RQ13]
							cnt_r   <= {2'b00, CLAMP_BASE << width_sel} - 8'h01;
						end
						else
							cnt_r <= cnt_r - 8'h01;
					end
				CL_PULSE:
					if (pixel_en)
					begin
						if (cnt_r == 8'h00)
						begin
							state_r <= CL_IDLE;
							clamp_r <= 1'b0;
						end
						else
							cnt_r <= cnt_r - 8'h01;
					end
				default:
					state_r <= CL_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	a_clamp_off_idle: assert property ( // [RQ14]
		!auto_en |=> !clamp_r)
		else $error("clamp pulse with auto clamp off");

endmodule : clamp_pulse_gen

// ### afe_main_ctl.sv
// Main control register bank on APB with test pattern and clamp logic
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module afe_main_ctl
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Data path
	input  wire logic [20:0] adc_word,
	input  wire logic        line_start_pulse,
	output logic      [20:0] out_word,
	// Analog and system controls
	output logic             sample_gain_two,
	output logic             data_out_en,
	output logic             analog_powerdown,
	output logic             sys_reset_pulse,
	output logic             scan_start_pulse,
	output logic             path_per_channel,
	output logic             input_clamp_pulse
);
	import afe_regs_pkg::*;

	logic [7:0]  cfg_one_r;
	logic [2:0]  two_r;
	logic [3:0]  three_r;
	logic [3:0]  four_r;
	logic [3:0]  clamp_r;
	logic [7:0]  clamp_pos_r;
	logic [7:0]  cnt_lo_r;
	logic [7:0]  cnt_mid_r;
	logic [4:0]  cnt_hi_r;
	logic [1:0]  clk_mode_r;
	logic        srst_r;
	logic        scan_r;
	logic        pready_r;
	logic        pslverr_r;
	logic [31:0] prdata_r;
	logic [20:0] out_r;
	logic [20:0] up_r;
	logic        alt_r;
	logic        path_r;
	logic [1:0]  pix_cnt_r;
	logic        pixel_en_r;
	logic [31:0] rd_nxt;
	logic        hit_nxt;
	logic [5:0]  idx;
	logic        wr;
	logic [2:0]  tp_mode;
	logic        lvds;
	logic        single_rate;

	assign idx         = paddr[7:2];
	assign wr          = psel & penable & pready_r & pwrite;
	assign tp_mode     = four_r[2:0];
	assign lvds        = ~cfg_one_r[B_OFMT];
	assign single_rate = (clk_mode_r == MODE_SINGLE);

	// Read decode; unmapped indices read zero and flag an error
	always_comb
	begin
		rd_nxt  = 32'h0000_0000;
		hit_nxt = 1'b1;
		unique case (idx)
			IDX_CFG_ONE:   rd_nxt[7:0] = cfg_one_r;
			IDX_CTL_TWO:   rd_nxt[4:0] = {two_r, srst_r, scan_r}; // [RQ5]
			IDX_CTL_THREE: rd_nxt[3:0] = three_r;
			IDX_CTL_FOUR:  rd_nxt[3:0] = four_r;
			IDX_CLAMP:     rd_nxt[3:0] = clamp_r;
			IDX_CLAMP_POS: rd_nxt[7:0] = clamp_pos_r;
			IDX_CNT_LO:    rd_nxt[7:0] = cnt_lo_r;
			IDX_CNT_MID:   rd_nxt[7:0] = cnt_mid_r;
			IDX_CNT_HI:    rd_nxt[4:0] = cnt_hi_r;
			IDX_CLK_MODE:  rd_nxt[1:0] = clk_mode_r;
			default:       hit_nxt     = 1'b0;
		endcase
	end

	// One wait state so that read data and ready leave flip-flops
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end
		else
		begin
			pready_r  <= psel & penable & ~pready_r;
			pslverr_r <= psel & penable & ~pready_r & ~hit_nxt;
			if (psel & penable & ~pready_r & ~pwrite)
				prdata_r <= rd_nxt;
		end
	end

	// Software reset strobe, one cycle, then clears itself [RQ4]
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			srst_r <= 1'b0;
		else
			srst_r <= wr & (idx == IDX_CTL_TWO) & pwdata[B_SRST] & ~srst_r;
	end

	// Scan start bit: one cycle high, a new write wins over the clear [RQ5]
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			scan_r <= 1'b0;
		else if (wr && idx == IDX_CTL_TWO && pwdata[B_SCAN])
			scan_r <= 1'b1;
		else
			scan_r <= 1'b0;
	end

	// Stored control fields; software reset restores defaults [RQ4]
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cfg_one_r   <= RST_CFG_ONE;
			two_r       <= RST_CTL_TWO[4:2];
			three_r     <= RST_CTL_THREE[3:0];
			four_r      <= RST_CTL_FOUR[3:0];
			clamp_r     <= RST_CLAMP[3:0];
			clamp_pos_r <= RST_CLAMP_POS;
			cnt_lo_r    <= RST_CNT;
			cnt_mid_r   <= RST_CNT;
			cnt_hi_r    <= RST_CNT[4:0];
			clk_mode_r  <= RST_CLK_MODE;
		end
		else if (srst_r)
		begin
			cfg_one_r   <= RST_CFG_ONE;
			two_r       <= RST_CTL_TWO[4:2]; // [RQ4]
			three_r     <= RST_CTL_THREE[3:0];
			four_r      <= RST_CTL_FOUR[3:0];
			clamp_r     <= RST_CLAMP[3:0];
			clamp_pos_r <= RST_CLAMP_POS;
			cnt_lo_r    <= RST_CNT;
			cnt_mid_r   <= RST_CNT;
			cnt_hi_r    <= RST_CNT[4:0];
			clk_mode_r  <= RST_CLK_MODE;
		end
		else if (wr)
		begin
			unique case (idx)
				IDX_CFG_ONE:   cfg_one_r   <= pwdata[7:0];
				IDX_CTL_TWO:   two_r       <= pwdata[4:2];
				IDX_CTL_THREE: three_r     <= pwdata[3:0];
				IDX_CTL_FOUR:  four_r      <= pwdata[3:0];
				IDX_CLAMP:     clamp_r     <= pwdata[3:0];
				IDX_CLAMP_POS: clamp_pos_r <= pwdata[7:0];
				IDX_CNT_LO:    cnt_lo_r    <= pwdata[7:0];
				IDX_CNT_MID:   cnt_mid_r   <= pwdata[7:0];
				IDX_CNT_HI:    cnt_hi_r    <= pwdata[4:0];
				IDX_CLK_MODE:  clk_mode_r  <= pwdata[1:0];
				default:       ;
			endcase
		end
	end

	// Pixel enable: every cycle in modes 0 and 1 (single rate is 1), every 2nd in mode 2, every 3rd in mode 3
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pix_cnt_r  <= 2'h0;
			pixel_en_r <= 1'b0;
		end
		else if (clk_mode_r <= MODE_SINGLE || pix_cnt_r >= clk_mode_r - 2'h1)
		begin
			pix_cnt_r  <= 2'h0;
			pixel_en_r <= 1'b1; // [RQ7]
		end
		else
		begin
			pix_cnt_r  <= pix_cnt_r + 2'h1;
			pixel_en_r <= 1'b0;
		end
	end

	// Override matters only in single rate; other modes use own paths
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			path_r <= 1'b0;
		else
			path_r <= three_r[B_OVR] | ~single_rate; // [RQ6]
	end

	// Pattern state: alternation runs in every test mode but 000, the free counter only in 010 with upcount
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			alt_r <= 1'b0;
			up_r  <= 21'h000000;
		end
		else if (srst_r || tp_mode == TP_NORMAL)
		begin
			alt_r <= 1'b0;
			up_r  <= 21'h000000;
		end
		else
		begin
			alt_r <= ~alt_r; // [RQ10]
			if (tp_mode == TP_COUNT && four_r[B_UPCNT])
				up_r <= (up_r == CNT_MAX) ? 21'h000000 : up_r + 21'h000001; // [RQ11]
		end
	end

	// Output word; patterns only in the serial format [RQ9]
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			out_r <= 21'h000000;
		else if (!lvds)
			out_r <= adc_word;
		else
		begin
			unique case (tp_mode)
				TP_NORMAL: out_r <= adc_word; // [RQ9]
				TP_ALT:    out_r <= alt_r ? PAT_B : PAT_A; // [RQ10]
				TP_COUNT:  out_r <= up_r; // [RQ11]
				TP_STATIC: out_r <= {cnt_hi_r, cnt_mid_r, cnt_lo_r}; // [RQ12]
				default:   out_r <= adc_word;
			endcase
		end
	end

	// Clamp pulse placed after the line start, width by code
	clamp_pulse_gen u_clamp
	(
		.ref_clk          (ref_clk),
		.arst_n           (arst_n),
		.pixel_en         (pixel_en_r),
		.line_start_pulse (line_start_pulse),
		.soft_rst         (srst_r),
		.auto_en          (clamp_r[B_AUTO]), // [RQ14]
		.width_sel        (clamp_r[B_CWID +: 2]), // [RQ13]
		.position         (clamp_pos_r),
		.clamp_r          (input_clamp_pulse)
	);

	// Ports straight from flip-flops
	assign prdata           = prdata_r;
	assign pready           = pready_r;
	assign pslverr          = pslverr_r;
	assign out_word         = out_r;
	assign sample_gain_two  = two_r[B_GAIN - 2]; // [RQ1]
	assign data_out_en      = two_r[B_OE - 2]; // [RQ2]
	assign analog_powerdown = two_r[B_PD - 2]; // [RQ3]
	assign sys_reset_pulse  = srst_r; // [RQ4]
	assign scan_start_pulse = scan_r; // [RQ5]
	assign path_per_channel = path_r;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence s_two_write(int b);
		wr && idx == IDX_CTL_TWO && pwdata[b];
	endsequence

	// Strobe high one cycle, then output enable, powerdown and test mode are back at defaults
	sequence s_back_to_defaults;
		sys_reset_pulse ##1 (!sys_reset_pulse && !data_out_en
		&& !analog_powerdown && tp_mode == TP_NORMAL);
	endsequence

	// Start strobe seen once, then low again
	sequence s_scan_strobe;
		scan_start_pulse ##1 !scan_start_pulse;
	endsequence

	a_gain_follows: assert property ( // [RQ1]
		wr && idx == IDX_CTL_TWO && !srst_r
		|=> sample_gain_two == $past(pwdata[B_GAIN]))
		else $error("gain select not taken from write");

	a_oe_follows: assert property ( // [RQ2]
		wr && idx == IDX_CTL_TWO && !srst_r
		|=> data_out_en == $past(pwdata[B_OE]))
		else $error("output enable not taken from write");

	a_pd_follows: assert property ( // [RQ3]
		wr && idx == IDX_CTL_TWO && !srst_r
		|=> analog_powerdown == $past(pwdata[B_PD]))
		else $error("powerdown not taken from write");

	a_srst_clears: assert property ( // [RQ4]
		s_two_write(B_SRST) ##0 !srst_r |=> s_back_to_defaults)
		else $error("software reset not one pulse then defaults");

	a_scan_self_clear: assert property ( // [RQ5]
		s_two_write(B_SCAN)
		##1 !(wr && idx == IDX_CTL_TWO && pwdata[B_SCAN])
		|-> s_scan_strobe)
		else $error("scan start bit did not clear itself");

	a_path_select: assert property ( // [RQ6]
		single_rate && !three_r[B_OVR] && $stable(three_r)
		&& $stable(clk_mode_r) |=> !path_per_channel)
		else $error("path override ignored in single rate");

	a_single_rate_pix: assert property ( // [RQ7]
		single_rate [*2] |=> pixel_en_r)
		else $error("pixel enable missing in single rate");

	a_tp_normal: assert property ( // [RQ9]
		$past(arst_n) && (tp_mode == TP_NORMAL || !lvds)
		|=> out_word == $past(adc_word))
		else $error("normal output replaced by pattern");

	a_tp_alternate: assert property ( // [RQ10]
		(lvds && tp_mode == TP_ALT) [*3]
		|-> out_word == ($past(out_word) == PAT_A ? PAT_B : PAT_A))
		else $error("alternating pattern did not alternate");

	a_tp_count: assert property ( // [RQ11]
		(lvds && tp_mode == TP_COUNT && four_r[B_UPCNT] && !srst_r) [*3]
		|-> out_word == $past(out_word) + 21'h000001
		|| ($past(out_word) == CNT_MAX && out_word == 21'h000000))
		else $error("count pattern did not step by one");

	a_tp_static: assert property ( // [RQ12]
		lvds && tp_mode == TP_STATIC
		|=> out_word == $past({cnt_hi_r, cnt_mid_r, cnt_lo_r}))
		else $error("static pattern not from count registers");

	a_clamp_width: assert property ( // [RQ13]
		$fell(input_clamp_pulse) && !$past(srst_r)
		&& $past(clamp_r[B_AUTO]) |-> $past(input_clamp_pulse, 4))
		else $error("clamp pulse shorter than four pixels");

endmodule : afe_main_ctl

// ### tb.sv
// Self-checking bench for the main control register bank
`timescale 1ns/1ps
module tb;
	import afe_regs_pkg::*;

	typedef struct packed
	{
		logic [7:0] wd;
		logic       g;
		logic       oe;
		logic       pd;
	} row_t;

	// Index with no register behind it
	localparam logic [5:0] IDX_NONE = 6'h3f;

	logic        ref_clk;
	logic        arst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [20:0] adc_word;
	logic        line_start_pulse;
	logic [20:0] out_word;
	logic        sample_gain_two;
	logic        data_out_en;
	logic        analog_powerdown;
	logic        sys_reset_pulse;
	logic        scan_start_pulse;
	logic        path_per_channel;
	logic        input_clamp_pulse;
	int          n_errors;
	int          checks;
	int          n;
	int          w;
	logic [31:0] rd;
	logic        err;
	logic [20:0] a;
	row_t        rows [5];

	afe_main_ctl dut_u
	(
		.ref_clk          (ref_clk),
		.arst_n           (arst_n),
		.psel             (psel),
		.penable          (penable),
		.pwrite           (pwrite),
		.paddr            (paddr),
		.pwdata           (pwdata),
		.prdata           (prdata),
		.pready           (pready),
		.pslverr          (pslverr),
		.adc_word         (adc_word),
		.line_start_pulse (line_start_pulse),
		.out_word         (out_word),
		.sample_gain_two  (sample_gain_two),
		.data_out_en      (data_out_en),
		.analog_powerdown (analog_powerdown),
		.sys_reset_pulse  (sys_reset_pulse),
		.scan_start_pulse (scan_start_pulse),
		.path_per_channel (path_per_channel),
		.input_clamp_pulse(input_clamp_pulse)
	);

	// 100 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			n_errors++;
		end
	endtask : chk

	// One APB transfer; waits on pready, bounded so a hang cannot stall
	task apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
		n = 0;
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (pready !== 1'b1)
		begin
			$display("ERROR pready expected 1 seen 0");
			n_errors++;
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [5:0] idx, input logic [7:0] d);
		apb(1'b1, idx, {24'h0, d});
	endtask : wr

	task rdchk(input string what, input logic [5:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 32'h0);
		chk(what, {24'h0, e}, rd);
	endtask : rdchk

	// Let register outputs and the registered data path land
	task settle;
		repeat (2) @(posedge ref_clk);
		#1;
	endtask : settle

	initial
	begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		adc_word = 21'h012345;
		line_start_pulse = 1'b0;
		n_errors = 0;
		checks = 0;
		rows[0] = '{8'h10, 1'b1, 1'b0, 1'b0};
		rows[1] = '{8'h08, 1'b0, 1'b1, 1'b0};
		rows[2] = '{8'h04, 1'b0, 1'b0, 1'b1};
		rows[3] = '{8'h1c, 1'b1, 1'b1, 1'b1};
		rows[4] = '{8'h00, 1'b0, 1'b0, 1'b0};
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		#1;
		chk("gain", 32'(0), 32'(sample_gain_two));
		chk("oe", 32'(0), 32'(data_out_en));
		chk("pd", 32'(0), 32'(analog_powerdown));
		rdchk("two", IDX_CTL_TWO, RST_CTL_TWO);
		rdchk("three", IDX_CTL_THREE, RST_CTL_THREE);
		rdchk("four", IDX_CTL_FOUR, RST_CTL_FOUR);
		rdchk("clamp", IDX_CLAMP, RST_CLAMP);
		$display("test reset done");
		// Control bits row by row
		foreach (rows[i])
		begin
			wr(IDX_CTL_TWO, rows[i].wd);
			settle();
			chk("gain", 32'(rows[i].g), 32'(sample_gain_two));
			chk("oe", 32'(rows[i].oe), 32'(data_out_en));
			chk("pd", 32'(rows[i].pd), 32'(analog_powerdown));
			rdchk("two", IDX_CTL_TWO, rows[i].wd);
		end
		$display("test control rows done");
		// Scan start pulses once and reads back as ready
		wr(IDX_CTL_TWO, 8'h01);
		#1;
		chk("scan", 32'(1), 32'(scan_start_pulse));
		chk("srst", 32'(0), 32'(sys_reset_pulse));
		@(posedge ref_clk);
		#1;
		chk("scan", 32'(0), 32'(scan_start_pulse));
		rdchk("two", IDX_CTL_TWO, 8'h00);
		$display("test scan done");
		// Override, then software reset must undo it; low bits kept ones
		wr(IDX_CTL_THREE, 8'h0f);
		settle();
		chk("path", 32'(1), 32'(path_per_channel));
		wr(IDX_CTL_TWO, 8'h12);
		#1;
		chk("srst", 32'(1), 32'(sys_reset_pulse));
		settle();
		chk("srst", 32'(0), 32'(sys_reset_pulse));
		chk("path", 32'(0), 32'(path_per_channel));
		rdchk("three", IDX_CTL_THREE, RST_CTL_THREE);
		rdchk("two", IDX_CTL_TWO, 8'h00);
		$display("test soft reset done");
		// Outside single rate each input keeps its own path
		wr(IDX_CLK_MODE, 8'h02);
		settle();
		chk("path", 32'(1), 32'(path_per_channel));
		wr(IDX_CLK_MODE, 8'h01);
		settle();
		chk("path", 32'(0), 32'(path_per_channel));
		$display("test path done");
		// Test patterns in serial format, then normal output with the format bit set
		@(posedge ref_clk);
		adc_word <= 21'h0abcde;
		settle();
		chk("normal", 32'(21'h0abcde), 32'(out_word));
		wr(IDX_CTL_FOUR, {5'h0, TP_ALT});
		settle();
		a = out_word;
		chk("alt", 32'(1), 32'((a === PAT_A) || (a === PAT_B)));
		@(posedge ref_clk);
		#1;
		chk("alt", 32'((a === PAT_A) ? PAT_B : PAT_A), 32'(out_word));
		wr(IDX_CTL_FOUR, 8'h0a);
		settle();
		a = out_word;
		repeat (4)
		begin
			@(posedge ref_clk);
			#1;
			a = a + 21'h1;
			chk("count", 32'(a), 32'(out_word));
		end
		wr(IDX_CTL_FOUR, {5'h0, TP_COUNT});
		settle();
		a = out_word;
		@(posedge ref_clk);
		#1;
		chk("hold", 32'(a), 32'(out_word));
		wr(IDX_CNT_LO, 8'h34);
		wr(IDX_CNT_MID, 8'h56);
		wr(IDX_CNT_HI, 8'h1b);
		wr(IDX_CTL_FOUR, {5'h0, TP_STATIC});
		settle();
		chk("static", 32'(21'h1b5634), 32'(out_word));
		wr(IDX_CFG_ONE, 8'h58);
		settle();
		chk("cmos", 32'(21'h0abcde), 32'(out_word));
		wr(IDX_CFG_ONE, RST_CFG_ONE);
		wr(IDX_CTL_FOUR, 8'h00);
		$display("test patterns done");
		// Clamp widths for each code, no delay beyond the fixed one
		wr(IDX_CLAMP_POS, 8'h00);
		for (int c = 0; c < 5; c++)
		begin
			wr(IDX_CLAMP, (c == 4) ? 8'h00 : 8'(c * 4 + 2));
			@(posedge ref_clk);
			line_start_pulse <= 1'b1;
			repeat (3) @(posedge ref_clk);
			line_start_pulse <= 1'b0;
			n = 0;
			w = 0;
			while (input_clamp_pulse !== 1'b1 && n < 20)
			begin
				@(posedge ref_clk);
				#1;
				n++;
			end
			while (input_clamp_pulse === 1'b1 && w < 40)
			begin
				@(posedge ref_clk);
				#1;
				w++;
			end
			chk("clamp_width", (c == 4) ? 32'(0) : 32'(4 << c), 32'(w));
		end
		$display("test clamp done");
		// Unmapped place refuses
		apb(1'b1, IDX_NONE, 32'hff);
		chk("slverr", 32'(1), 32'(err));
		apb(1'b0, IDX_NONE, 32'h0);
		chk("slverr", 32'(1), 32'(err));
		chk("unmapped", 32'h0, rd);
		$display("test unmapped done");
		// Reset in mid-run clears the control bits
		wr(IDX_CTL_TWO, 8'h18);
		settle();
		arst_n <= 1'b0;
		#2;
		chk("gain", 32'(0), 32'(sample_gain_two));
		chk("oe", 32'(0), 32'(data_out_en));
		@(posedge ref_clk);
		arst_n <= 1'b1;
		rdchk("two", IDX_CTL_TWO, RST_CTL_TWO);
		$display("test second reset done");
		tally_and_finish();
	end
endmodule : tb
